// ==== hw/smca_consts.svh ====
`ifndef SMCA_CONSTS_SVH
`define SMCA_CONSTS_SVH
`define SMCA_MODE_SPD_TRQ 16'h0003
`define SMCA_MODE_TRQ_POS 16'h0005
`define SMCA_ZERO_SPEED 16'h0032
`define SMCA_BUS_UV_LIMIT 16'h00C8
`define SMCA_PFAIL_MS 60
`define SMCA_CLK_MHZ 50
`define SMCA_PFAIL_CYC (`SMCA_PFAIL_MS * 1000 * `SMCA_CLK_MHZ)
`define SMCA_AL_NONE 8'h00
`define SMCA_AL_UV 8'h10
`define SMCA_AL_OC 8'h32
`define SMCA_AL_OL1 8'h50
`define SMCA_AL_OL2 8'h51
`endif

// ==== hw/smca_ctrl.sv ====
`timescale 1ns/100ps
`include "smca_consts.svh"
// control mode change and alarm handling
module smca_ctrl (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // configuration
    input wire logic [15:0] I_CTRL_MODE_PARAM,
    input wire logic I_INCREMENTAL,
    input wire logic [15:0] I_ACC_STEP,
    input wire logic [15:0] I_DEC_STEP,
    input wire logic signed [15:0] I_INT_SPEED_CMD1,
    input wire logic [15:0] I_INT_SPEED_LIM1,
    // contact inputs
    input wire logic I_CONTROL_MODE_SELECT,
    input wire logic I_SPEED_SELECT_BIT0,
    input wire logic I_FORWARD_START_INPUT,
    input wire logic I_REVERSE_START_INPUT,
    input wire logic I_ALARM_CLEAR_INPUT,
    input wire logic I_SERVO_ON_INPUT,
    // analog references and measurements
    input wire logic signed [15:0] I_ANALOG_SPEED_REFERENCE,
    input wire logic [15:0] I_ANALOG_SPEED_LIMIT,
    input wire logic signed [15:0] I_MEAS_SPEED,
    input wire logic [15:0] I_BUS_VOLTAGE,
    // alarm causes, and the set key that requests an alarm reset
    input wire logic I_CTRL_POWER_OK,
    input wire logic I_OVERCURRENT,
    input wire logic I_OVERLOAD1,
    input wire logic I_OVERLOAD2,
    input wire logic I_SET_KEY,
    // home return finished by the position sequencer
    input wire logic I_HOME_RETURN_DONE,
    // droop counter
    input wire logic I_DROOP_INC,
    input wire logic I_DROOP_DEC,
    // outputs
    output smca_pkg::smca_loop_t O_ACTIVE_LOOP,
    output logic signed [15:0] O_SPEED_CMD,
    output logic [15:0] O_SPEED_LIM,
    output logic O_BASE_DRIVE_EN,
    output logic O_ALARM,
    output logic [7:0] O_ALARM_CODE,
    output logic O_HOME_VALID,
    output logic O_ZERO_SPEED_FLAG,
    output logic O_SPEED_LIMIT_REACHED,
    output logic [31:0] O_DROOP_COUNT
);
    import smca_pkg::*;

    // sampled contacts
    logic [5:0] cont;
    logic sel, sp1, st1, st2, clr, servo_on_input;
    smca_sync u_sync (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_raw({I_SERVO_ON_INPUT, I_ALARM_CLEAR_INPUT, I_REVERSE_START_INPUT,
                I_FORWARD_START_INPUT, I_SPEED_SELECT_BIT0, I_CONTROL_MODE_SELECT}),
        .o_sync(cont)
    );
    assign {servo_on_input, clr, st2, st1, sp1, sel} = cont;

    // zero-speed flag from measured speed magnitude
    logic [15:0] abs_speed;
    logic zero_speed;
    assign abs_speed = I_MEAS_SPEED[15] ? 16'(-I_MEAS_SPEED) : I_MEAS_SPEED;
    assign zero_speed = (abs_speed <= `SMCA_ZERO_SPEED);

    // mode decoding
    logic mode_st, mode_tp;
    assign mode_st = (I_CTRL_MODE_PARAM == `SMCA_MODE_SPD_TRQ);
    assign mode_tp = (I_CTRL_MODE_PARAM == `SMCA_MODE_TRQ_POS);

    function automatic smca_loop_t loop_of(input logic st, input logic s);
        if (st) begin
            return s ? SMCA_TORQUE : SMCA_SPEED;
        end
        return s ? SMCA_POSITION : SMCA_TORQUE;
    endfunction

    // select edge handling and loop choice
    logic sel_prev_ff;
    smca_loop_t loop_ff, nxt_loop;
    logic sel_edge, accept;
    assign sel_edge = (sel != sel_prev_ff);
    // in torque/position mode a toggle outside zero speed is dropped for good, since only the edge acts
    assign accept = sel_edge && (mode_st || zero_speed);
    always_comb begin
        if (!(mode_st || mode_tp)) begin
            nxt_loop = SMCA_SPEED;
        end else if (accept) begin
            nxt_loop = loop_of(mode_st, sel);
        end else if (mode_st && !(loop_ff inside {SMCA_SPEED, SMCA_TORQUE})) begin
            nxt_loop = loop_of(1'b1, sel);
        end else if (mode_tp && loop_ff == SMCA_SPEED) begin
            nxt_loop = loop_of(1'b0, sel);
        end else begin
            nxt_loop = loop_ff;
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            sel_prev_ff <= 1'b0;
            loop_ff <= SMCA_SPEED;
        end else begin
            sel_prev_ff <= sel;
            loop_ff <= nxt_loop;
        end
    end
    assign O_ACTIVE_LOOP = loop_ff;

    // droop pulse counter, cleared when leaving position control
    logic [31:0] droop_ff;
    logic droop_clr;
    assign droop_clr = (loop_ff == SMCA_POSITION) && (nxt_loop == SMCA_TORQUE);
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            droop_ff <= 32'h0000_0000;
        end else if (droop_clr || loop_ff != SMCA_POSITION) begin
            droop_ff <= 32'h0000_0000;
        end else if (I_DROOP_INC && !I_DROOP_DEC) begin
            droop_ff <= droop_ff + 32'h0000_0001;
        end else if (I_DROOP_DEC && !I_DROOP_INC) begin
            droop_ff <= droop_ff - 32'h0000_0001;
        end
    end
    assign O_DROOP_COUNT = droop_ff;

    // alarm causes
    logic [31:0] pfail_cnt_ff;
    logic pfail_long_ff, pwr_prev_ff, uv_cond;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            pfail_cnt_ff <= 32'h0000_0000;
            pfail_long_ff <= 1'b0;
            pwr_prev_ff <= 1'b1;
        end else begin
            pwr_prev_ff <= I_CTRL_POWER_OK;
            if (I_CTRL_POWER_OK) begin
                pfail_cnt_ff <= 32'h0000_0000;
                if (pwr_prev_ff) begin
                    pfail_long_ff <= 1'b0;
                end
            end else if (pfail_cnt_ff < 32'(`SMCA_PFAIL_CYC)) begin
                pfail_cnt_ff <= pfail_cnt_ff + 32'h0000_0001;
            end else begin
                pfail_long_ff <= 1'b1;
            end
        end
    end
    // undervoltage on return after long loss, or low bus
    assign uv_cond = (I_CTRL_POWER_OK && !pwr_prev_ff && pfail_long_ff)
        || (I_BUS_VOLTAGE <= `SMCA_BUS_UV_LIMIT);

    logic cause_any;
    logic [7:0] new_code;
    assign cause_any = uv_cond || I_OVERCURRENT || I_OVERLOAD1 || I_OVERLOAD2;
    assign new_code = uv_cond ? `SMCA_AL_UV :
        I_OVERCURRENT ? `SMCA_AL_OC :
        I_OVERLOAD1 ? `SMCA_AL_OL1 :
        I_OVERLOAD2 ? `SMCA_AL_OL2 : `SMCA_AL_NONE;
    // cause still present for the latched code
    logic cause_held;
    always_comb begin
        unique case (O_ALARM_CODE)
            `SMCA_AL_OC: cause_held = I_OVERCURRENT;
            `SMCA_AL_OL1: cause_held = I_OVERLOAD1;
            `SMCA_AL_OL2: cause_held = I_OVERLOAD2;
            `SMCA_AL_UV: cause_held = (I_BUS_VOLTAGE <= `SMCA_BUS_UV_LIMIT);
            default: cause_held = 1'b0;
        endcase
    end

    // reset requests: clear input rising edge, set key, or power returning after a short loss
    logic clr_prev_ff, reset_req;
    assign reset_req = (clr && !clr_prev_ff) || I_SET_KEY
        || (I_CTRL_POWER_OK && !pwr_prev_ff && !pfail_long_ff);

    logic alarm_ff;
    logic [7:0] code_ff;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            alarm_ff <= 1'b0;
            code_ff <= `SMCA_AL_NONE;
            clr_prev_ff <= 1'b0;
        end else begin
            clr_prev_ff <= clr;
            if (!alarm_ff && cause_any) begin
                alarm_ff <= 1'b1;
                code_ff <= new_code;
            end else if (alarm_ff && reset_req && !cause_held && !cause_any) begin
                alarm_ff <= 1'b0;
                code_ff <= `SMCA_AL_NONE;
            end
        end
    end
    assign O_ALARM = alarm_ff;
    assign O_ALARM_CODE = code_ff;

    // base drive cut combinationally the moment a cause appears
    assign O_BASE_DRIVE_EN = servo_on_input && !alarm_ff && !cause_any;

    // home position invalidated by any alarm in incremental position control
    logic home_ff;
    logic home_lost;
    assign home_lost = (cause_any || alarm_ff) && I_INCREMENTAL && loop_ff == SMCA_POSITION;
    // loss wins over a home return reported in the same cycle
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            home_ff <= 1'b0;
        end else if (home_lost) begin
            home_ff <= 1'b0;
        end else if (I_HOME_RETURN_DONE && loop_ff == SMCA_POSITION) begin
            home_ff <= 1'b1;
        end
    end
    assign O_HOME_VALID = home_ff;

    // speed reference and limit selection
    logic signed [15:0] target;
    logic run;
    assign run = (st1 ^ st2) && O_BASE_DRIVE_EN;  // both or neither released: stop
    assign target = (loop_ff != SMCA_SPEED || !run) ? 16'sh0000 :
        (sp1 ? I_INT_SPEED_CMD1 : I_ANALOG_SPEED_REFERENCE);
    smca_ramp u_ramp (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_target(target),
        .i_acc_step(I_ACC_STEP),
        .i_dec_step(I_DEC_STEP),
        .o_ramp(O_SPEED_CMD)
    );
    logic [15:0] lim_sel;
    assign lim_sel = sp1 ? I_INT_SPEED_LIM1 : I_ANALOG_SPEED_LIMIT;
    logic [15:0] lim_ff;
    logic reached_ff;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            lim_ff <= 16'h0000;
            reached_ff <= 1'b0;
        end else begin
            lim_ff <= lim_sel;
            reached_ff <= (loop_ff == SMCA_TORQUE) && (abs_speed >= lim_sel);
        end
    end
    assign O_SPEED_LIM = lim_ff;
    assign O_SPEED_LIMIT_REACHED = reached_ff;
    assign O_ZERO_SPEED_FLAG = zero_speed;

    // assertions
    a_base_drive_off: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        O_ALARM |-> !O_BASE_DRIVE_EN) else $error("base drive on during alarm");
    a_tp_no_move: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (mode_tp && !zero_speed && $past(mode_tp)) |=> $stable(loop_ff) || !$past(mode_tp))
        else $error("loop changed above zero speed");
    a_st_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (mode_st && sel_edge) |=> loop_ff == (sel_prev_ff ? SMCA_TORQUE : SMCA_SPEED))
        else $error("speed/torque change not applied");
    a_droop_clear: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        droop_clr |=> droop_ff == 32'h0000_0000) else $error("droop not cleared");
    a_cause_blocks: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (alarm_ff && cause_held) |=> alarm_ff) else $error("alarm cleared with cause");
    a_oc_code: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (!alarm_ff && I_OVERCURRENT && !uv_cond) |=> code_ff == `SMCA_AL_OC)
        else $error("wrong overcurrent code");
    a_alarm_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        cause_any |=> alarm_ff) else $error("alarm not raised");
    a_home_lost: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (alarm_ff && I_INCREMENTAL && loop_ff == SMCA_POSITION) |=> !home_ff)
        else $error("home kept after alarm");
    a_home_needs_done: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (!home_ff && !I_HOME_RETURN_DONE) |=> !home_ff)
        else $error("home set without home return");
endmodule // smca_ctrl

// ==== hw/smca_pkg.sv ====
package smca_pkg;
    typedef enum logic [1:0] {SMCA_SPEED, SMCA_TORQUE, SMCA_POSITION} smca_loop_t;
endpackage

// ==== hw/smca_ramp.sv ====
`timescale 1ns/100ps
// speed reference ramp limited by acceleration and deceleration steps
module smca_ramp (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // target and rates
    input wire logic signed [15:0] i_target,
    input wire logic [15:0] i_acc_step,
    input wire logic [15:0] i_dec_step,
    // ramped output
    output logic signed [15:0] o_ramp
);
    logic signed [15:0] ramp_ff;
    logic signed [16:0] diff;
    logic signed [16:0] acc_s;
    logic signed [16:0] dec_s;
    logic signed [15:0] nxt_ramp;
    logic away;
    assign diff = 17'(i_target) - 17'(ramp_ff);
    assign acc_s = 17'({1'b0, i_acc_step});
    assign dec_s = 17'({1'b0, i_dec_step});
    // moving away from zero accelerates, toward zero decelerates
    assign away = (diff > 0) ? (ramp_ff >= 0) : (ramp_ff <= 0);
    always_comb begin
        if (diff > 0) begin
            nxt_ramp = (diff > (away ? acc_s : dec_s)) ?
                16'(ramp_ff + (away ? acc_s : dec_s)) : i_target;
        end else if (diff < 0) begin
            nxt_ramp = (-diff > (away ? acc_s : dec_s)) ?
                16'(ramp_ff - (away ? acc_s : dec_s)) : i_target;
        end else begin
            nxt_ramp = ramp_ff;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ramp_ff <= 16'sh0000;
        end else begin
            ramp_ff <= nxt_ramp;
        end
    end
    assign o_ramp = ramp_ff;
endmodule // smca_ramp

// ==== hw/smca_sync.sv ====
`timescale 1ns/100ps
// two-stage sampler for a group of contact inputs
module smca_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // raw and sampled contacts
    input wire logic [5:0] i_raw,
    output logic [5:0] o_sync
);
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_ff <= 6'h00;
            sync_ff <= 6'h00;
        end else begin
            meta_ff <= i_raw;
            sync_ff <= meta_ff;
        end
    end
    assign o_sync = sync_ff;
endmodule // smca_sync

// ==== sim/smca_ctrl_test.sv ====
`timescale 1ns/100ps
// self-checking bench for mode change and alarm handling
module smca_ctrl_test;
    import smca_pkg::*;
    logic clk, rstn, incr, set_key, dinc, ddec, pwr_ok, alarm, base_en, home, zero_speed_flag, speed_limit_reached;
    logic home_done;
    logic [15:0] mode, acc, dec, lim1, alim, bus;
    logic signed [15:0] cmd1, aref, meas;
    logic [5:0] req;
    logic [2:0] cause;
    logic sel_c, spd_c, fwd_c, rev_c, clr_c, son_c;
    smca_loop_t loop;
    logic signed [15:0] scmd;
    logic [15:0] slim;
    logic [7:0] code;
    logic [31:0] droop;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] codes [3] = '{8'h32, 8'h50, 8'h51};

    smca_seq_model partner (.i_clk(clk), .i_req(req), .i_alarm(alarm), .o_select(sel_c),
        .o_speed_bit(spd_c), .o_fwd(fwd_c), .o_rev(rev_c), .o_clear(clr_c), .o_son(son_c));

    smca_ctrl uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CTRL_MODE_PARAM(mode),
        .I_INCREMENTAL(incr), .I_ACC_STEP(acc), .I_DEC_STEP(dec), .I_INT_SPEED_CMD1(cmd1),
        .I_INT_SPEED_LIM1(lim1), .I_CONTROL_MODE_SELECT(sel_c), .I_SPEED_SELECT_BIT0(spd_c),
        .I_FORWARD_START_INPUT(fwd_c), .I_REVERSE_START_INPUT(rev_c),
        .I_ALARM_CLEAR_INPUT(clr_c), .I_SERVO_ON_INPUT(son_c),
        .I_ANALOG_SPEED_REFERENCE(aref), .I_ANALOG_SPEED_LIMIT(alim), .I_MEAS_SPEED(meas),
        .I_BUS_VOLTAGE(bus), .I_CTRL_POWER_OK(pwr_ok), .I_OVERCURRENT(cause[0]),
        .I_OVERLOAD1(cause[1]), .I_OVERLOAD2(cause[2]), .I_SET_KEY(set_key),
        .I_HOME_RETURN_DONE(home_done),
        .I_DROOP_INC(dinc), .I_DROOP_DEC(ddec), .O_ACTIVE_LOOP(loop), .O_SPEED_CMD(scmd),
        .O_SPEED_LIM(slim), .O_BASE_DRIVE_EN(base_en), .O_ALARM(alarm), .O_ALARM_CODE(code),
        .O_HOME_VALID(home), .O_ZERO_SPEED_FLAG(zero_speed_flag), .O_SPEED_LIMIT_REACHED(speed_limit_reached),
        .O_DROOP_COUNT(droop));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one contact request through the sequence controller, then let it pass the sampler
    task automatic contact(input int idx, input logic val);
        @(posedge clk) req[idx] <= val;
        tick(8);
    endtask

    task automatic clear_pulse();
        contact(4, 1'b1);
        contact(4, 1'b0);
    endtask

    initial begin
        {rstn, incr, set_key, dinc, ddec, req, cause, home_done} = '0;
        pwr_ok = 1'b1;
        mode = 16'h0003;
        acc = 16'h0010;
        dec = 16'h0020;
        cmd1 = 16'sh0100;
        lim1 = 16'h0300;
        alim = 16'h0400;
        aref = 16'sh0200;
        meas = 16'sh0000;
        bus = 16'h0136;
        tick(20);
        @(posedge clk) rstn <= 1'b1;
        tick(2);
        check(loop, SMCA_SPEED);
        check({alarm, code, home}, 10'h000);
        check(droop, 32'h0000_0000);
        // speed mode: analog reference then internal command 1, ramped
        contact(5, 1'b1);
        contact(2, 1'b1);
        check(scmd, 16'h0050);
        tick(60);
        check(scmd, 16'h0200);
        contact(1, 1'b1);
        check(scmd, 16'h0160);
        tick(40);
        check(scmd, 16'h0100);
        // torque mode at speed, limits from internal then analog source
        @(posedge clk) meas <= 16'sh0400;
        contact(0, 1'b1);
        check(loop, SMCA_TORQUE);
        check(slim, 16'h0300);
        check(speed_limit_reached, 1'b1);
        contact(1, 1'b0);
        check(slim, 16'h0400);
        // back to speed with both starts released: decelerate to stop
        contact(0, 1'b0);
        check(loop, SMCA_SPEED);
        check(speed_limit_reached, 1'b0);
        contact(2, 1'b0);
        tick(60);
        check(scmd, 16'h0000);
        // torque/position change mode
        @(posedge clk) begin
            mode <= 16'h0005;
            meas <= 16'sh0000;
        end
        contact(0, 1'b1);
        check(loop, SMCA_POSITION);
        @(posedge clk) dinc <= 1'b1;
        tick(5);
        @(posedge clk) dinc <= 1'b0;
        tick(2);
        check(droop, 32'h0000_0006);
        contact(0, 1'b0);
        check(loop, SMCA_TORQUE);
        check(droop, 32'h0000_0000);
        @(posedge clk) meas <= 16'sh0400;
        contact(0, 1'b1);
        check(loop, SMCA_TORQUE);
        @(posedge clk) meas <= 16'sh0000;
        tick(10);
        check(loop, SMCA_TORQUE);
        // zero speed threshold boundaries
        @(posedge clk) meas <= 16'sh0032;
        tick(1);
        check(zero_speed_flag, 1'b1);
        @(posedge clk) meas <= -16'sh0032;
        tick(1);
        check(zero_speed_flag, 1'b1);
        @(posedge clk) meas <= 16'sh0033;
        tick(1);
        check(zero_speed_flag, 1'b0);
        // home return in incremental position control, lost on the next alarm
        @(posedge clk) begin
            meas <= 16'sh0000;
            incr <= 1'b1;
        end
        contact(0, 1'b0);
        contact(0, 1'b1);
        check(loop, SMCA_POSITION);
        check(home, 1'b0);
        @(posedge clk) home_done <= 1'b1;
        @(posedge clk) home_done <= 1'b0;
        tick(1);
        check(home, 1'b1);
        // overcurrent and overloads: drive cut, reset refused while cause stays
        for (int k = 0; k < 3; k++) begin
            contact(5, 1'b0);
            contact(5, 1'b1);
            check(base_en, 1'b1);
            @(posedge clk) cause <= 3'b001 << k;
            tick(0);
            check(base_en, 1'b0);
            tick(3);
            check({alarm, code}, {1'b1, codes[k]});
            check(home, 1'b0);
            clear_pulse();
            check(alarm, 1'b1);
            @(posedge clk) cause <= 3'b000;
            tick(2);
            check(base_en, 1'b0);
            if (k == 0) begin
                clear_pulse();
            end else if (k == 1) begin
                @(posedge clk) pwr_ok <= 1'b0;
                tick(3);
                @(posedge clk) pwr_ok <= 1'b1;
                tick(2);
            end else begin
                @(posedge clk) set_key <= 1'b1;
                @(posedge clk) set_key <= 1'b0;
                tick(4);
            end
            check({alarm, code}, 9'h000);
        end
        // bus undervoltage boundary
        @(posedge clk) bus <= 16'h00C9;
        tick(4);
        check(alarm, 1'b0);
        @(posedge clk) bus <= 16'h00C8;
        tick(4);
        check({alarm, code}, 9'h110);
        @(posedge clk) bus <= 16'h0136;
        clear_pulse();
        check(alarm, 1'b0);
        finish_test();
    end
endmodule // smca_ctrl_test

// ==== sim/smca_seq_model.sv ====
`timescale 1ns/100ps
// behavioural sequence controller that drives the amplifier contact inputs
module smca_seq_model (
    // clock
    input wire logic i_clk,
    // bench requests: 0 select, 1 speed bit, 2 forward, 3 reverse, 4 clear, 5 servo on
    input wire logic [5:0] i_req,
    input wire logic i_alarm,
    // contact outputs, 1 = shorted
    output logic o_select,
    output logic o_speed_bit,
    output logic o_fwd,
    output logic o_rev,
    output logic o_clear,
    output logic o_son
);
    logic son_lock;

    // contacts open at power up
    initial begin
        {o_select, o_speed_bit, o_fwd, o_rev, o_clear, o_son, son_lock} = 7'h00;
    end

    // contacts follow requests one edge later; servo on held off after an alarm
    always @(posedge i_clk) begin
        if (i_alarm) begin
            son_lock <= 1'b1;
        end else if (!i_req[5]) begin
            son_lock <= 1'b0;
        end
        o_select <= i_req[0];
        o_speed_bit <= i_req[1];
        o_fwd <= i_req[2];
        o_rev <= i_req[3];
        o_clear <= i_req[4];
        o_son <= i_req[5] & !i_alarm & !son_lock;
    end
endmodule // smca_seq_model
